// ### core/ofc_regs.vh
/*
 Register map, field layout, reset values and state codes of the
 oscillator and frequency locked loop control block.
 Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
// Behaviour
// (R1) Slow oscillator always runs except during reset
// (R2) Slow trim loads factory value, write overrides
// (R3) Fast RC oscillator is default clock source
// (R4) RC enable write starts/stops; poll readback
// (R5) Software waits full stop/start before toggling
// (R6) RC trim loads factory; range and trim writable
// (R7) Software changes RC range/trim while disabled
// (R8) Loop resets to open-loop using written trims
// (R9) Open-loop trims writable; ready after enable
// (R10) Software: reference, steps, multiplier, then mode
// (R11) Software keeps step maxima at half range
// (R12) Closed loop targets multiplier times reference
// (R13) Closed-loop trims read-only, coarse is start point
// (R14) Coarse lock first, then fine lock
// (R15) Lock flags raise enabled interrupt
// (R16) Ratio error stores measured minus multiplier
// (R17) Unfrozen tracking adjusts fine, keeps locks
// (R18) Fine overflow or coarse failure sets out-of-bounds
// (R19) Software rewrites multiplier after out-of-bounds
// (R20) Slow or stopped reference sets stopped flag; the code sets it only in closed-loop mode
// (R21) Stopped reference acts open-loop, resumes after
// (R22) Chill cycles on by default, disable bit
// (R23) Quick lock on by default, disable bit
// (R24) Lose-lock bit decides lock retention on disable
// (R25) Disabling loop clears ready flag
`ifndef OFC_REGS_VH
`define OFC_REGS_VH

// ----------------------------------------
// Register word indices (byte address bits 4:2)
// ----------------------------------------
`define OFC_ULP_CTRL 3'h0
`define OFC_RC_CTRL 3'h1
`define OFC_LOOP_CTRL 3'h2
`define OFC_LOOP_VAL 3'h3
`define OFC_LOOP_MUL 3'h4
`define OFC_STATUS 3'h5
`define OFC_IRQ_EN 3'h6

// ----------------------------------------
// Field positions
// ----------------------------------------
`define OFC_ULP_TRIM 4:0
`define OFC_RC_TRIM 11:0
`define OFC_RC_RANGE 17:16
`define OFC_RC_ENABLE 1
`define OFC_LC_ENABLE 1
`define OFC_LC_MODE 2
`define OFC_LC_FREEZE 3
`define OFC_LC_LOSE_LOCK_ON_WAKE 4
`define OFC_LC_CHILL_DIS 8
`define OFC_LC_QL_DIS 9
`define OFC_LV_FINE 9:0
`define OFC_LV_COARSE 15:10
`define OFC_LV_ERR 31:16
`define OFC_LM_TARGET 15:0
`define OFC_LM_SMALL_STEP_MAX 25:16
`define OFC_LM_BIG_STEP_MAX 31:26
`define OFC_ST_FLAGS 4:0
`define OFC_ST_PEND 12:8

// ----------------------------------------
// Reset values, limits and tolerances
// ----------------------------------------
`define OFC_COARSE_MAX 6'h3F
`define OFC_FINE_MAX 10'h3FF
`define OFC_FINE_MID 10'h200
`define OFC_CTOL 16'h0008
`define OFC_FTOL_QUICK 16'h0002
`define OFC_FTOL_STRICT 16'h0000
`define OFC_SRC_RC 2'h1

// ----------------------------------------
// Tuner states
// ----------------------------------------
`define OFC_S_OPEN 2'h0
`define OFC_S_COARSE 2'h1
`define OFC_S_FINE 2'h2
`define OFC_S_TRACK 2'h3

`endif

// ### core/ofc_top.v
/*
 Oscillator and frequency locked loop control: trims for the slow
 and fast RC oscillators, and the loop tuner with coarse/fine lock,
 ratio error, drift tracking and reference stop detection.
 Assumes a synchronous Avalon-MM master on I_CORE_CLK and a reference
 clock from the generic clock unit that is slow against the core clock.
 One core clock cycle stands in for one loop output cycle.
*/
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`include "ofc_regs.vh"

module ofc_top #(
  parameter REF_STOP_CYC = 131072,
  parameter RC_START_CYC = 16,
  parameter LOOP_START_CYC = 16
) (
  input wire I_CORE_CLK,
  input wire I_NRST,
  input wire [4:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  output reg [31:0] O_AVS_READDATA,
  output reg O_AVS_WAITREQUEST,
  input wire I_REF_CLK,
  input wire [4:0] I_FACT_ULP_TRIM,
  input wire [11:0] I_FACT_RC_TRIM,
  input wire [5:0] I_FACT_COARSE,
  output reg O_ULP_RUN,
  output reg [4:0] O_ULP_TRIM,
  output reg [1:0] O_SRC_SEL,
  output reg O_RC_EN,
  output reg [1:0] O_RC_RANGE,
  output reg [11:0] O_RC_TRIM,
  output reg O_LOOP_EN,
  output reg [5:0] O_LOOP_COARSE,
  output reg [9:0] O_LOOP_FINE,
  output reg O_IRQ
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg ref_s1_reg;
  reg ref_s2_reg;
  reg ref_s3_reg;
  reg [22:0] fact_s1_reg;
  reg [22:0] fact_s2_reg;
  reg [1:0] ld_cnt_reg;
  reg rc_on_reg;
  reg [15:0] rc_cnt_reg;
  reg mode_reg;
  reg freeze_reg;
  reg lose_lock_on_wake_reg;
  reg chill_dis_reg;
  reg ql_dis_reg;
  reg [15:0] target_reg;
  reg [9:0] small_step_max_max_reg;
  reg [5:0] big_step_max_max_reg;
  reg [15:0] err_reg;
  reg [4:0] irq_en_reg;
  reg [4:0] pend_reg;
  reg ready_reg;
  reg [15:0] start_cnt_reg;
  reg [15:0] meas_cnt_reg;
  reg [15:0] meas_reg;
  reg meas_vld_reg;
  reg [23:0] stop_cnt_reg;
  reg stop_reg;
  reg chill_skip_reg;
  reg [1:0] st_reg;
  reg [5:0] big_step_max_reg;
  reg [9:0] small_step_max_reg;
  reg lockc_reg;
  reg lockf_reg;
  reg oob_reg;
  reg [4:0] flags_d_reg;
  reg [31:0] rd_next;

  wire bus_req;
  wire wr;
  wire [2:0] idx;
  wire ref_edge;
  wire [16:0] ratio_error;
  wire slow;
  wire [15:0] mag;
  wire [15:0] ftol;
  wire use_meas;
  wire mul_wr;
  wire [4:0] flags;
  wire [4:0] rise;
  wire [4:0] pend_next;

  // ----------------------------------------
  // Avalon-MM slave
  // ----------------------------------------
  assign bus_req = I_AVS_READ | I_AVS_WRITE;
  assign wr = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
  assign idx = I_AVS_ADDRESS[4:2];

  // One wait state: drop waitrequest, complete on the next edge
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_AVS_WAITREQUEST <= 1'b1;
      O_AVS_READDATA <= 32'h00000000;
    end else if (bus_req && O_AVS_WAITREQUEST) begin
      O_AVS_WAITREQUEST <= 1'b0;
      O_AVS_READDATA <= rd_next;
    end else begin
      O_AVS_WAITREQUEST <= 1'b1;
    end
  end

  // Read mux; unmapped words read zero
  always @* begin
    rd_next = 32'h00000000;
    case (idx)
      `OFC_ULP_CTRL: rd_next[`OFC_ULP_TRIM] = O_ULP_TRIM;
      `OFC_RC_CTRL: begin
        rd_next[`OFC_RC_TRIM] = O_RC_TRIM;
        rd_next[`OFC_RC_RANGE] = O_RC_RANGE;
        rd_next[`OFC_RC_ENABLE] = rc_on_reg; // R4
      end
      `OFC_LOOP_CTRL: begin
        rd_next[`OFC_LC_ENABLE] = O_LOOP_EN;
        rd_next[`OFC_LC_MODE] = mode_reg;
        rd_next[`OFC_LC_FREEZE] = freeze_reg;
        rd_next[`OFC_LC_LOSE_LOCK_ON_WAKE] = lose_lock_on_wake_reg;
        rd_next[`OFC_LC_CHILL_DIS] = chill_dis_reg;
        rd_next[`OFC_LC_QL_DIS] = ql_dis_reg;
      end
      `OFC_LOOP_VAL: begin
        rd_next[`OFC_LV_FINE] = O_LOOP_FINE;
        rd_next[`OFC_LV_COARSE] = O_LOOP_COARSE;
        rd_next[`OFC_LV_ERR] = err_reg; // R16
      end
      `OFC_LOOP_MUL: begin
        rd_next[`OFC_LM_TARGET] = target_reg;
        rd_next[`OFC_LM_SMALL_STEP_MAX] = small_step_max_max_reg;
        rd_next[`OFC_LM_BIG_STEP_MAX] = big_step_max_max_reg;
      end
      `OFC_STATUS: begin
        rd_next[`OFC_ST_FLAGS] = flags;
        rd_next[`OFC_ST_PEND] = pend_reg;
      end
      `OFC_IRQ_EN: rd_next[`OFC_ST_FLAGS] = irq_en_reg;
      default: rd_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Factory trims are pins; sync before the one-time load
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      ref_s1_reg <= 1'b0;
      ref_s2_reg <= 1'b0;
      ref_s3_reg <= 1'b0;
      fact_s1_reg <= 23'h000000;
      fact_s2_reg <= 23'h000000;
    end else begin
      ref_s1_reg <= I_REF_CLK;
      ref_s2_reg <= ref_s1_reg;
      ref_s3_reg <= ref_s2_reg;
      fact_s1_reg <= {I_FACT_ULP_TRIM, I_FACT_RC_TRIM, I_FACT_COARSE};
      fact_s2_reg <= fact_s1_reg;
    end
  end

  assign ref_edge = ref_s2_reg & ~ref_s3_reg;

  // ----------------------------------------
  // Slow and fast RC oscillators
  // ----------------------------------------
  // Trims loaded on the third edge after release, once the
  // synchronisers hold the factory value; later writes win.
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      ld_cnt_reg <= 2'h0;
      O_ULP_RUN <= 1'b0;
      O_SRC_SEL <= `OFC_SRC_RC;
      O_ULP_TRIM <= 5'h00;
      O_RC_TRIM <= 12'h000;
      O_RC_RANGE <= 2'h0;
      O_RC_EN <= 1'b1;
    end else begin
      O_ULP_RUN <= 1'b1; // R1
      O_SRC_SEL <= `OFC_SRC_RC; // R3
      if (ld_cnt_reg != 2'h3) begin
        ld_cnt_reg <= ld_cnt_reg + 2'h1;
      end
      if (ld_cnt_reg == 2'h2) begin
        O_ULP_TRIM <= fact_s2_reg[22:18]; // R2
        O_RC_TRIM <= fact_s2_reg[17:6]; // R6
      end else if (wr && idx == `OFC_ULP_CTRL) begin
        O_ULP_TRIM <= I_AVS_WRITEDATA[`OFC_ULP_TRIM]; // R2
      end else if (wr && idx == `OFC_RC_CTRL) begin
        O_RC_TRIM <= I_AVS_WRITEDATA[`OFC_RC_TRIM]; // R6
      end
      if (wr && idx == `OFC_RC_CTRL) begin
        O_RC_RANGE <= I_AVS_WRITEDATA[`OFC_RC_RANGE]; // R6
        O_RC_EN <= I_AVS_WRITEDATA[`OFC_RC_ENABLE]; // R4
      end
    end
  end

  // Readback follows the request only after the start/stop delay
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      rc_on_reg <= 1'b1;
      rc_cnt_reg <= 16'h0000;
    end else if (O_RC_EN == rc_on_reg) begin
      rc_cnt_reg <= 16'h0000;
    end else if (rc_cnt_reg == RC_START_CYC[15:0] - 16'h0001) begin
      rc_on_reg <= O_RC_EN; // R4
      rc_cnt_reg <= 16'h0000;
    end else begin
      rc_cnt_reg <= rc_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Loop control and multiplier registers
  // ----------------------------------------
  assign mul_wr = wr && idx == `OFC_LOOP_MUL;

  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      O_LOOP_EN <= 1'b0;
      mode_reg <= 1'b0; // R8
      freeze_reg <= 1'b0;
      lose_lock_on_wake_reg <= 1'b0;
      chill_dis_reg <= 1'b0; // R22
      ql_dis_reg <= 1'b0; // R23
      target_reg <= 16'h0000;
      small_step_max_max_reg <= 10'h001;
      big_step_max_max_reg <= 6'h01;
      irq_en_reg <= 5'h00;
    end else begin
      if (wr && idx == `OFC_LOOP_CTRL) begin
        O_LOOP_EN <= I_AVS_WRITEDATA[`OFC_LC_ENABLE];
        mode_reg <= I_AVS_WRITEDATA[`OFC_LC_MODE];
        freeze_reg <= I_AVS_WRITEDATA[`OFC_LC_FREEZE];
        lose_lock_on_wake_reg <= I_AVS_WRITEDATA[`OFC_LC_LOSE_LOCK_ON_WAKE];
        chill_dis_reg <= I_AVS_WRITEDATA[`OFC_LC_CHILL_DIS]; // R22
        ql_dis_reg <= I_AVS_WRITEDATA[`OFC_LC_QL_DIS]; // R23
      end
      if (mul_wr) begin
        target_reg <= I_AVS_WRITEDATA[`OFC_LM_TARGET];
        small_step_max_max_reg <= I_AVS_WRITEDATA[`OFC_LM_SMALL_STEP_MAX];
        big_step_max_max_reg <= I_AVS_WRITEDATA[`OFC_LM_BIG_STEP_MAX];
      end
      if (wr && idx == `OFC_IRQ_EN) begin
        irq_en_reg <= I_AVS_WRITEDATA[`OFC_ST_FLAGS];
      end
    end
  end

  // Ready after the start delay; cleared at once on disable
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      ready_reg <= 1'b0;
      start_cnt_reg <= 16'h0000;
    end else if (!O_LOOP_EN) begin
      ready_reg <= 1'b0; // R25
      start_cnt_reg <= 16'h0000;
    end else if (!ready_reg) begin
      if (start_cnt_reg == LOOP_START_CYC[15:0] - 16'h0001) begin
        ready_reg <= 1'b1; // R9
      end
      start_cnt_reg <= start_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------
  // Ratio measurement and reference stop
  // ----------------------------------------
  // Output cycles per reference period, saturating
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      meas_cnt_reg <= 16'h0000;
      meas_reg <= 16'h0000;
      meas_vld_reg <= 1'b0;
      stop_cnt_reg <= 24'h000000;
      stop_reg <= 1'b0;
      chill_skip_reg <= 1'b0;
    end else begin
      meas_vld_reg <= 1'b0;
      if (ref_edge) begin
        meas_reg <= meas_cnt_reg;
        meas_cnt_reg <= 16'h0001;
        stop_cnt_reg <= 24'h000000;
        stop_reg <= 1'b0; // R21
        // A chill period drops every other measurement
        chill_skip_reg <= ~chill_skip_reg & ~chill_dis_reg; // R22
        meas_vld_reg <= ~stop_reg & (chill_dis_reg | ~chill_skip_reg);
      end else begin
        if (meas_cnt_reg != 16'hFFFF) begin
          meas_cnt_reg <= meas_cnt_reg + 16'h0001;
        end
        if (stop_cnt_reg >= REF_STOP_CYC[23:0] - 24'h000001) begin
          stop_reg <= mode_reg; // R20
        end else begin
          stop_cnt_reg <= stop_cnt_reg + 24'h000001;
        end
      end
    end
  end

  assign ratio_error = {1'b0, meas_reg} - {1'b0, target_reg}; // R12
  assign slow = ratio_error[16];
  assign mag = slow ? (16'h0000 - ratio_error[15:0]) : ratio_error[15:0];
  assign ftol = ql_dis_reg ? `OFC_FTOL_STRICT : `OFC_FTOL_QUICK; // R23
  assign use_meas = meas_vld_reg & mode_reg & ready_reg & ~stop_reg;

  // ----------------------------------------
  // Frequency tuner
  // ----------------------------------------
  // Step halves on each move: a binary search toward the target.
  // A target below the loop minimum pins coarse at zero.
  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      st_reg <= `OFC_S_OPEN;
      O_LOOP_COARSE <= 6'h00;
      O_LOOP_FINE <= `OFC_FINE_MID;
      big_step_max_reg <= 6'h01;
      small_step_max_reg <= 10'h001;
      lockc_reg <= 1'b0;
      lockf_reg <= 1'b0;
      oob_reg <= 1'b0;
      err_reg <= 16'h0000;
    end else begin
      if (ld_cnt_reg == 2'h2) begin
        O_LOOP_COARSE <= fact_s2_reg[5:0];
      end
      if (use_meas) begin
        err_reg <= ratio_error[15:0]; // R16
      end
      if (mul_wr) begin
        oob_reg <= 1'b0; // R19
      end
      // Open loop first, so trim writes land even while disabled
      if (!mode_reg) begin
        st_reg <= `OFC_S_OPEN;
        lockc_reg <= 1'b0;
        lockf_reg <= 1'b0;
        if (wr && idx == `OFC_LOOP_VAL) begin
          O_LOOP_FINE <= I_AVS_WRITEDATA[`OFC_LV_FINE]; // R9
          O_LOOP_COARSE <= I_AVS_WRITEDATA[`OFC_LV_COARSE];
        end
      end else if (!O_LOOP_EN && lose_lock_on_wake_reg) begin
        st_reg <= `OFC_S_OPEN; // R24
        lockc_reg <= 1'b0;
        lockf_reg <= 1'b0;
      end else begin
        case (st_reg)
          `OFC_S_OPEN: begin
            if (O_LOOP_EN) begin
              st_reg <= `OFC_S_COARSE; // R13
              big_step_max_reg <= big_step_max_max_reg;
            end
          end
          `OFC_S_COARSE: begin
            if (mul_wr) begin
              big_step_max_reg <= I_AVS_WRITEDATA[`OFC_LM_BIG_STEP_MAX];
            end else if (use_meas) begin
              if (mag <= `OFC_CTOL) begin
                lockc_reg <= 1'b1; // R14
                st_reg <= `OFC_S_FINE;
                small_step_max_reg <= small_step_max_max_reg;
              end else if (slow) begin
                if (O_LOOP_COARSE == `OFC_COARSE_MAX) begin
                  oob_reg <= 1'b1; // R18
                end else if (`OFC_COARSE_MAX - O_LOOP_COARSE < big_step_max_reg) begin
                  O_LOOP_COARSE <= `OFC_COARSE_MAX;
                end else begin
                  O_LOOP_COARSE <= O_LOOP_COARSE + big_step_max_reg;
                end
              end else begin
                if (O_LOOP_COARSE == 6'h00) begin
                  oob_reg <= 1'b1; // R18
                end else if (O_LOOP_COARSE < big_step_max_reg) begin
                  O_LOOP_COARSE <= 6'h00;
                end else begin
                  O_LOOP_COARSE <= O_LOOP_COARSE - big_step_max_reg;
                end
              end
              if (use_meas && mag > `OFC_CTOL && big_step_max_reg > 6'h01) begin
                big_step_max_reg <= {1'b0, big_step_max_reg[5:1]};
              end
            end
          end
          `OFC_S_FINE: begin
            if (use_meas) begin
              if (mag <= ftol) begin
                lockf_reg <= 1'b1; // R14
                st_reg <= `OFC_S_TRACK;
              end else if (slow) begin
                if (`OFC_FINE_MAX - O_LOOP_FINE < small_step_max_reg) begin
                  O_LOOP_FINE <= `OFC_FINE_MAX;
                  oob_reg <= 1'b1; // R18
                end else begin
                  O_LOOP_FINE <= O_LOOP_FINE + small_step_max_reg;
                end
              end else begin
                if (O_LOOP_FINE < small_step_max_reg) begin
                  O_LOOP_FINE <= 10'h000;
                  oob_reg <= 1'b1; // R18
                end else begin
                  O_LOOP_FINE <= O_LOOP_FINE - small_step_max_reg;
                end
              end
              if (mag > ftol && small_step_max_reg > 10'h001) begin
                small_step_max_reg <= {1'b0, small_step_max_reg[9:1]};
              end
            end
          end
          `OFC_S_TRACK: begin
            // Drift follow by single fine steps; locks stay set
            if (use_meas && !freeze_reg && mag > ftol) begin
              if (slow) begin
                if (O_LOOP_FINE == `OFC_FINE_MAX) begin
                  oob_reg <= 1'b1; // R18
                end else begin
                  O_LOOP_FINE <= O_LOOP_FINE + 10'h001; // R17
                end
              end else begin
                if (O_LOOP_FINE == 10'h000) begin
                  oob_reg <= 1'b1; // R18
                end else begin
                  O_LOOP_FINE <= O_LOOP_FINE - 10'h001; // R17
                end
              end
            end
          end
          default: st_reg <= `OFC_S_OPEN;
        endcase
        // Restart the lock sequence after a multiplier rewrite
        if (mul_wr && st_reg != `OFC_S_OPEN) begin
          st_reg <= `OFC_S_COARSE; // R19
          lockc_reg <= 1'b0;
          lockf_reg <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Status flags and interrupt
  // ----------------------------------------
  assign flags = {stop_reg, oob_reg, lockf_reg, lockc_reg, ready_reg};
  assign rise = flags & ~flags_d_reg;
  // Write one clears a pending bit; a new rise in that cycle wins
  assign pend_next = (pend_reg & ~((wr && idx == `OFC_STATUS) ?
    I_AVS_WRITEDATA[`OFC_ST_PEND] : 5'h00)) | rise;

  always @(posedge I_CORE_CLK) begin
    if (!I_NRST) begin
      flags_d_reg <= 5'h00;
      pend_reg <= 5'h00;
      O_IRQ <= 1'b0;
    end else begin
      flags_d_reg <= flags;
      pend_reg <= pend_next; // R18 R20
      O_IRQ <= |(pend_next & irq_en_reg); // R15
    end
  end

endmodule

// ### tb/ofc_chk_props.sv
/*
 Port checker for the oscillator and loop control block.
 Assumes it is bound to ofc_top and sees only that module's ports.
*/
`timescale 1ns/1ps
module ofc_chk #(
  parameter REF_STOP_CYC = 131072,
  parameter RC_START_CYC = 16,
  parameter LOOP_START_CYC = 16
) (
  input wire I_CORE_CLK,
  input wire I_NRST,
  input wire [4:0] I_AVS_ADDRESS,
  input wire I_AVS_READ,
  input wire I_AVS_WRITE,
  input wire [31:0] I_AVS_WRITEDATA,
  input wire [31:0] O_AVS_READDATA,
  input wire O_AVS_WAITREQUEST,
  input wire O_ULP_RUN,
  input wire [4:0] O_ULP_TRIM,
  input wire [1:0] O_SRC_SEL,
  input wire O_RC_EN,
  input wire [1:0] O_RC_RANGE,
  input wire [11:0] O_RC_TRIM,
  input wire O_LOOP_EN,
  input wire [5:0] O_LOOP_COARSE,
  input wire [9:0] O_LOOP_FINE,
  input wire O_IRQ
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  reg [31:0] wd_reg;
  reg mode_reg;
  wire wr_done = I_AVS_WRITE && !O_AVS_WAITREQUEST;
  wire [2:0] wa = I_AVS_ADDRESS[4:2];
  // Mode copy, since loop trims accept writes only in open loop
  always @(posedge I_CORE_CLK) begin
    wd_reg <= I_AVS_WRITEDATA;
    if (!I_NRST)
      mode_reg <= 1'b0;
    else if (wr_done && wa == 3'h2)
      mode_reg <= I_AVS_WRITEDATA[2];
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_NRST);

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ulp_run;
    I_NRST |=> O_ULP_RUN;
  endproperty
  a_ulp_run: assert property (p_ulp_run) else $error("slow oscillator stopped");
  property p_src_sel;
    O_SRC_SEL == 2'h1;
  endproperty
  a_src_sel: assert property (p_src_sel) else $error("default source not RC");
  property p_ulp_wr;
    wr_done && wa == 3'h0 |=> O_ULP_TRIM == wd_reg[4:0];
  endproperty
  a_ulp_wr: assert property (p_ulp_wr) else $error("slow trim write lost");
  property p_ulp_rd;
    I_AVS_READ && !O_AVS_WAITREQUEST && wa == 3'h0 |-> O_AVS_READDATA[4:0] == O_ULP_TRIM;
  endproperty
  a_ulp_rd: assert property (p_ulp_rd) else $error("slow trim readback wrong");
  property p_rc_en;
    wr_done && wa == 3'h1 |=> O_RC_EN == wd_reg[1];
  endproperty
  a_rc_en: assert property (p_rc_en) else $error("RC enable not following write");
  property p_rc_fld;
    wr_done && wa == 3'h1 |=> O_RC_RANGE == wd_reg[17:16] && O_RC_TRIM == wd_reg[11:0];
  endproperty
  a_rc_fld: assert property (p_rc_fld) else $error("RC range or trim wrong");
  property p_loop_en;
    wr_done && wa == 3'h2 |=> O_LOOP_EN == wd_reg[1];
  endproperty
  a_loop_en: assert property (p_loop_en) else $error("loop enable wrong");
  property p_loop_val;
    wr_done && wa == 3'h3 && !mode_reg |=> {O_LOOP_COARSE, O_LOOP_FINE} == wd_reg[15:0];
  endproperty
  a_loop_val: assert property (p_loop_val) else $error("open-loop trims not taken");
  property p_irq_off;
    wr_done && wa == 3'h6 && I_AVS_WRITEDATA[4:0] == 5'h00 |=> ##1 !O_IRQ;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("masked interrupt still high");
endmodule

bind ofc_top ofc_chk #(.REF_STOP_CYC(REF_STOP_CYC), .RC_START_CYC(RC_START_CYC),
  .LOOP_START_CYC(LOOP_START_CYC)) u_chk (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
  .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
  .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(O_AVS_READDATA),
  .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .O_ULP_RUN(O_ULP_RUN), .O_ULP_TRIM(O_ULP_TRIM),
  .O_SRC_SEL(O_SRC_SEL), .O_RC_EN(O_RC_EN), .O_RC_RANGE(O_RC_RANGE), .O_RC_TRIM(O_RC_TRIM),
  .O_LOOP_EN(O_LOOP_EN), .O_LOOP_COARSE(O_LOOP_COARSE), .O_LOOP_FINE(O_LOOP_FINE), .O_IRQ(O_IRQ));

// ### tb/tb_ofc_top.sv
/*
 Self-checking bench for ofc_top: bus tasks and register sequences.
 Assumes one wait state per access and a reference made here.
*/
`timescale 1ns/1ps
module tb_ofc_top;
  integer half = 20;
  localparam [31:0] MUL_OK = 32'h21000028;
  logic I_CORE_CLK = 1'b0;
  logic I_NRST = 1'b0;
  logic [4:0] I_AVS_ADDRESS = 5'h00;
  logic I_AVS_READ = 1'b0;
  logic I_AVS_WRITE = 1'b0;
  logic [31:0] I_AVS_WRITEDATA = 32'h00000000;
  logic I_REF_CLK = 1'b0;
  wire [31:0] O_AVS_READDATA;
  wire O_AVS_WAITREQUEST, O_ULP_RUN, O_RC_EN, O_LOOP_EN, O_IRQ;
  wire [4:0] O_ULP_TRIM;
  wire [1:0] O_SRC_SEL, O_RC_RANGE;
  wire [11:0] O_RC_TRIM;
  wire [5:0] O_LOOP_COARSE;
  wire [9:0] O_LOOP_FINE;
  logic [31:0] rdat;
  logic [31:0] keep;
  logic ref_on = 1'b0;
  integer ref_cnt = 0;
  integer n_mismatch = 0;
  integer n_compared = 0;

  ofc_top #(.REF_STOP_CYC(64)) dut_u (.I_CORE_CLK(I_CORE_CLK), .I_NRST(I_NRST),
    .I_AVS_ADDRESS(I_AVS_ADDRESS), .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE),
    .I_AVS_WRITEDATA(I_AVS_WRITEDATA), .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST), .I_REF_CLK(I_REF_CLK), .I_FACT_ULP_TRIM(5'h15),
    .I_FACT_RC_TRIM(12'hA5C), .I_FACT_COARSE(6'h15), .O_ULP_RUN(O_ULP_RUN), .O_ULP_TRIM(O_ULP_TRIM),
    .O_SRC_SEL(O_SRC_SEL), .O_RC_EN(O_RC_EN), .O_RC_RANGE(O_RC_RANGE), .O_RC_TRIM(O_RC_TRIM),
    .O_LOOP_EN(O_LOOP_EN), .O_LOOP_COARSE(O_LOOP_COARSE), .O_LOOP_FINE(O_LOOP_FINE), .O_IRQ(O_IRQ));

  // ----------------------------------------
  // Clock and reference
  // ----------------------------------------
  always #2.5 I_CORE_CLK = ~I_CORE_CLK;
  // Whole core cycles per half period, so each measurement is exact
  always @(posedge I_CORE_CLK) begin
    if (ref_on) begin
      ref_cnt <= (ref_cnt >= half - 1) ? 0 : ref_cnt + 1;
      if (ref_cnt >= half - 1)
        I_REF_CLK <= ~I_REF_CLK;
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  // One access; request held until waitrequest is seen low
  task bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
    begin
      @(posedge I_CORE_CLK);
      I_AVS_READ <= rd;
      I_AVS_WRITE <= !rd;
      I_AVS_ADDRESS <= a;
      I_AVS_WRITEDATA <= d;
      @(posedge I_CORE_CLK);
      while (O_AVS_WAITREQUEST !== 1'b0)
        @(posedge I_CORE_CLK);
      rdat = O_AVS_READDATA;
      I_AVS_READ <= 1'b0;
      I_AVS_WRITE <= 1'b0;
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // Bounded polling; status bits may take many measurements
  task poll(input logic [4:0] a, input logic [31:0] m, input logic [31:0] v);
    integer i;
    begin
      i = 0;
      do begin
        bus(1'b1, a, 32'h0);
        i = i + 1;
      end while ((rdat & m) !== v && i < 10000);
      chk(rdat & m, v);
    end
  endtask

  task finish_test;
    begin
      if (n_mismatch == 0 && n_compared > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask

  // ----------------------------------------
  // Watchdog and sequence
  // ----------------------------------------
  initial begin
    #450000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end

  initial begin
    repeat (3) @(posedge I_CORE_CLK);
    I_NRST <= 1'b1;
    repeat (4) @(negedge I_CORE_CLK);
    chk(32'(O_ULP_RUN), 32'h1);
    chk(32'(O_SRC_SEL), 32'h1);
    chk(32'(O_ULP_TRIM), 32'h15);
    chk(32'(O_RC_TRIM), 32'hA5C);
    bus(1'b1, 5'h08, 32'h0);
    chk(rdat & 32'h304, 32'h0);
    bus(1'b1, 5'h1C, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b0, 5'h00, 32'h0000000A);
    bus(1'b1, 5'h00, 32'h0);
    chk(rdat & 32'h1F, 32'h0A);
    // RC stop, range change while stopped, restart
    poll(5'h04, 32'h2, 32'h2);
    bus(1'b0, 5'h04, 32'h00000A5C);
    poll(5'h04, 32'h2, 32'h0);
    bus(1'b0, 5'h04, 32'h00020A5E);
    @(negedge I_CORE_CLK);
    chk({O_RC_EN, O_RC_RANGE, O_RC_TRIM}, 32'h6A5E);
    poll(5'h04, 32'h2, 32'h2);
    // Open loop
    bus(1'b0, 5'h08, 32'h2);
    poll(5'h14, 32'h1, 32'h1);
    bus(1'b0, 5'h0C, 32'h000054F3);
    @(negedge I_CORE_CLK);
    chk({O_LOOP_EN, O_LOOP_COARSE, O_LOOP_FINE}, 32'h154F3);
    // Closed loop: reference, steps and multiplier, then mode
    bus(1'b0, 5'h18, 32'h0E);
    ref_on <= 1'b1;
    bus(1'b0, 5'h10, MUL_OK);
    bus(1'b0, 5'h08, 32'h6);
    poll(5'h14, 32'h6, 32'h6);
    @(negedge I_CORE_CLK);
    chk(32'(O_IRQ), 32'h1);
    bus(1'b0, 5'h0C, 32'h0);
    bus(1'b1, 5'h0C, 32'h0);
    chk(rdat & 32'hFFFFFC00, 32'h00005400);
    bus(1'b0, 5'h14, 32'h1F00);
    repeat (2) @(negedge I_CORE_CLK);
    chk(32'(O_IRQ), 32'h0);
    // Target off by five: coarse holds, fine runs out
    bus(1'b0, 5'h10, MUL_OK + 32'h5);
    poll(5'h0C, 32'hFFFF0000, 32'hFFFB0000);
    poll(5'h14, 32'h8, 32'h8);
    @(negedge I_CORE_CLK);
    chk(32'(O_IRQ), 32'h1);
    bus(1'b0, 5'h10, MUL_OK);
    poll(5'h14, 32'h8, 32'h0);
    poll(5'h14, 32'h6, 32'h6);
    // Drift: slower reference, fine follows one step at a time
    half <= 22;
    poll(5'h0C, 32'h3FF, 32'h3FD);
    poll(5'h14, 32'h6, 32'h6);
    // Frozen tracking must hold fine despite the error
    bus(1'b0, 5'h08, 32'hE);
    bus(1'b1, 5'h0C, 32'h0);
    keep = rdat;
    repeat (400) @(negedge I_CORE_CLK);
    bus(1'b1, 5'h0C, 32'h0);
    chk(rdat & 32'h3FF, keep & 32'h3FF);
    bus(1'b0, 5'h08, 32'h6);
    half <= 20;
    // Reference stop and restart
    ref_on <= 1'b0;
    poll(5'h14, 32'h10, 32'h10);
    ref_on <= 1'b1;
    poll(5'h14, 32'h10, 32'h0);
    // Disable keeping locks, then disable losing them
    bus(1'b0, 5'h08, 32'h4);
    poll(5'h14, 32'h1, 32'h0);
    chk(rdat & 32'h6, 32'h6);
    bus(1'b0, 5'h08, 32'h6);
    poll(5'h14, 32'h1, 32'h1);
    bus(1'b0, 5'h08, 32'h14);
    poll(5'h14, 32'h7, 32'h0);
    bus(1'b0, 5'h08, 32'h300);
    bus(1'b1, 5'h08, 32'h0);
    chk(rdat & 32'h304, 32'h300);
    bus(1'b0, 5'h0C, 32'h00001234);
    @(negedge I_CORE_CLK);
    chk({O_LOOP_COARSE, O_LOOP_FINE}, 32'h1234);
    bus(1'b0, 5'h18, 32'h0);
    repeat (3) @(negedge I_CORE_CLK);
    chk(32'(O_IRQ), 32'h0);
    finish_test;
  end
endmodule
